/* File: hw/apm_pkg.sv */
package apm_pkg;

    // ----------------------------------------------------------------
    // register offsets (byte addresses)
    // ----------------------------------------------------------------
    localparam logic [7:0] APM_OFF_CTRL   = 8'h00; // axi_monitor_control
    localparam logic [7:0] APM_OFF_THR    = 8'h04; // axi_monitor_latency_threshold
    localparam logic [7:0] APM_OFF_FILT   = 8'h08; // axi_monitor_filter_irq
    localparam logic [7:0] APM_OFF_MAXLAT = 8'h30; // largest read latency
    localparam logic [7:0] APM_OFF_OVERCT = 8'h38; // reads over the limit
    localparam logic [7:0] APM_OFF_RDCNT  = 8'h3c; // counted reads
    localparam logic [7:0] APM_OFF_WRCNT  = 8'h40; // counted writes
    localparam logic [7:0] APM_OFF_STAT   = 8'h48; // sticky event status
    localparam logic [7:0] APM_OFF_MASK   = 8'h4c; // event mask

    // ----------------------------------------------------------------
    // field positions
    // ----------------------------------------------------------------
    localparam int APM_WE_LSB      = 16; // write-enable half
    localparam int APM_B_RUN       = 0;  // monitor_run
    localparam int APM_B_WIPE      = 1;  // counter_wipe
    localparam int APM_B_MODE      = 2;  // count_mode_select
    localparam int APM_B_WRAP      = 3;  // wrap_test_select
    localparam int APM_B_RDFILT    = 4;  // read_id_filter_on
    localparam int APM_B_WRFILT    = 5;  // write_id_filter_on
    localparam int APM_LATID_LSB   = 8;  // latency_id_select 13:8
    localparam int APM_B_LATRANGE  = 15; // latency_id_range_on
    localparam int APM_WRID_LSB    = 8;  // write_id_match 12:8
    localparam int APM_B_IRQALLOW  = 14; // irq_allow
    localparam int APM_B_IRQWIPE   = 15; // irq_flag_wipe, self-clearing
    localparam int APM_ST_OVER     = 0;  // a read went over the limit
    localparam int APM_ST_WRAPPED  = 1;  // a counter rolled over

    // ----------------------------------------------------------------
    // writable-bit masks and reset values
    // ----------------------------------------------------------------
    localparam logic [15:0] APM_CTRL_WMASK = 16'hbfff; // bit 14 reserved
    localparam logic [15:0] APM_THR_WMASK  = 16'h0fff; // 15:12 reserved
    localparam logic [15:0] APM_FILT_WMASK = 16'h5f3f; // 15 is a pulse
    localparam logic [15:0] APM_CTRL_RST   = 16'h0000;
    localparam logic [15:0] APM_THR_RST    = 16'h0000;
    localparam logic [15:0] APM_FILT_RST   = 16'h0000;
    localparam logic [1:0]  APM_EVT_RST    = 2'h0;

    // ----------------------------------------------------------------
    // axi constants and widths
    // ----------------------------------------------------------------
    localparam logic [1:0] APM_BURST_WRAP = 2'h2;
    localparam int APM_LAT_W  = 13; // latency measurement width
    localparam int APM_LIM_W  = 12; // read_latency_limit width
    localparam int APM_RID_W  = 6;
    localparam int APM_WID_W  = 5;

    // address channel observation
    typedef struct packed {
        logic       valid;
        logic       ready;
        logic [5:0] id;
        logic [7:0] len;
        logic [1:0] burst;
    } apm_addr_obs_t;

    // read data channel observation
    typedef struct packed {
        logic       valid;
        logic       ready;
        logic       last;
        logic [5:0] id;
    } apm_rdata_obs_t;

endpackage

/* File: hw/apm_event_counter.sv */
`timescale 1ns/1ns
`default_nettype none
// ------------------------------------------------------------------
// wrapping event counter with hold-at-zero clear
// ------------------------------------------------------------------
module apm_event_counter #(
    parameter int W   = 32,
    parameter int STEP_W = 9
) (
    input  wire logic              clk,
    input  wire logic              rst_b,
    input  wire logic              wipe,     // holds count at zero
    input  wire logic              inc,      // add step this cycle
    input  wire logic [STEP_W-1:0] step,     // amount to add
    output logic      [W-1:0]      count,    // running total
    output logic                   wrapped   // pulse on roll-over
);
    logic [W:0]   sum;       // one bit wider to see the carry
    logic [W-1:0] count_reg;
    logic [W-1:0] count_next;
    logic         wrap_reg;
    logic         wrap_next;

    // next value: wipe dominates so software sees a clean zero
    always_comb begin
        sum        = {1'b0, count_reg} + {{(W+1-STEP_W){1'b0}}, step};
        count_next = count_reg;
        wrap_next  = 1'b0;
        if (wipe) begin
            count_next = '0;
        end else if (inc) begin
            count_next = sum[W-1:0];
            wrap_next  = sum[W];
        end
    end

    // register stage
    always_ff @(posedge clk) begin
        if (!rst_b) begin
            count_reg <= '0;
            wrap_reg  <= 1'b0;
        end else begin
            count_reg <= count_next;
            wrap_reg  <= wrap_next;
        end
    end

    assign count   = count_reg;
    assign wrapped = wrap_reg;

    // wipe clears the total one edge later
    wipe_zero_a: assert property (@(posedge clk) disable iff (!rst_b)
        wipe |=> count == '0)
        else $error("counter not held at zero by wipe");
endmodule
`default_nettype wire

/* File: hw/apm_monitor_ctrl.sv */
// The APB slave port is this design's own decision.
`timescale 1ns/1ns
`default_nettype none
// Functional notes
// - upper half write-enables matching lower bit
// - mode bit picks transactions or beats
// - wrap bit counts only wrapping bursts
// - read filter restricts reads to match ID
// - write filter restricts writes to match ID
// - write ID match at bits 12:8
// - read ID match at bits 5:0
// - 12-bit latency limit, 15:12 read zero
// - latency ID restriction enable and select
// - 32-bit count of over-limit reads
// - 13-bit maximum read latency, resets zero
module apm_monitor_ctrl
    import apm_pkg::*;
#(
    parameter int CNT_W = 32 // result counter width
) (
    input  wire logic           clk,
    input  wire logic           rst_b,
    // apb slave
    input  wire logic           psel,
    input  wire logic           penable,
    input  wire logic           pwrite,
    input  wire logic [7:0]     paddr,
    input  wire logic [31:0]    pwdata,
    output logic      [31:0]    prdata,
    output logic                pready,
    output logic                pslverr,
    // observed axi channels
    input  wire apm_addr_obs_t  arObs,
    input  wire apm_rdata_obs_t rObs,
    input  wire apm_addr_obs_t  awObs,
    // interrupt level
    output logic                irq
);
    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic        setupPh;      // first cycle of a transfer
    logic        wrTake;       // write lands at this edge
    logic        mapped;       // address hits a register
    logic [31:0] rdMux;        // read data before the flop
    logic [31:0] prdata_reg;
    logic [31:0] prdata_next;
    logic        pready_reg;
    logic        pready_next;
    logic        pslverr_reg;
    logic        pslverr_next;

    assign setupPh = psel && !penable;
    assign wrTake  = psel && penable && pready_reg && pwrite && !pslverr_reg;

    // ----------------------------------------------------------------
    // control registers
    // ----------------------------------------------------------------
    logic [15:0] ctrl_reg, ctrl_next;  // axi_monitor_control
    logic [15:0] thr_reg,  thr_next;   // axi_monitor_latency_threshold
    logic [15:0] filt_reg, filt_next;  // axi_monitor_filter_irq
    logic [1:0]  stat_reg, stat_next;  // sticky events
    logic [1:0]  mask_reg, mask_next;  // event mask
    logic        irqWipe;              // irq_flag_wipe pulse
    logic        irq_reg,  irq_next;

    // masked write: bit n moves only when bit n+16 is set
    function automatic logic [15:0] apm_merge(input logic [15:0] old,
                                              input logic [31:0] wd,
                                              input logic [15:0] keep);
        logic [15:0] en;
        en = wd[31:APM_WE_LSB] & keep;
        return (old & ~en) | (wd[15:0] & en);
    endfunction

    // field views
    logic                 monitorRun, counterWipe, countModeSelect, wrapTestSelect;
    logic                 readIdFilterOn, writeIdFilterOn, latencyIdRangeOn, irqAllow;
    logic [APM_RID_W-1:0] latencyIdSelect, readIdMatch;
    logic [APM_WID_W-1:0] writeIdMatch;
    logic [APM_LIM_W-1:0] readLatencyLimit;

    assign monitorRun       = ctrl_reg[APM_B_RUN];
    assign counterWipe      = ctrl_reg[APM_B_WIPE];
    assign countModeSelect  = ctrl_reg[APM_B_MODE];
    assign wrapTestSelect   = ctrl_reg[APM_B_WRAP];
    assign readIdFilterOn   = ctrl_reg[APM_B_RDFILT];
    assign writeIdFilterOn  = ctrl_reg[APM_B_WRFILT];
    assign latencyIdRangeOn = ctrl_reg[APM_B_LATRANGE];
    assign latencyIdSelect  = ctrl_reg[APM_LATID_LSB +: APM_RID_W];
    assign readLatencyLimit = thr_reg[APM_LIM_W-1:0];
    assign readIdMatch      = filt_reg[APM_RID_W-1:0];
    assign writeIdMatch     = filt_reg[APM_WRID_LSB +: APM_WID_W];
    assign irqAllow         = filt_reg[APM_B_IRQALLOW];

    // ----------------------------------------------------------------
    // transaction qualification
    // ----------------------------------------------------------------
    logic       arHs, awHs, rHs;   // handshakes
    logic       rdQual, wrQual;    // counted this cycle
    logic [8:0] rdStep, wrStep;    // amount to add

    assign arHs = arObs.valid && arObs.ready;
    assign awHs = awObs.valid && awObs.ready;
    assign rHs  = rObs.valid && rObs.ready;

    // qualifiers: run, id filter, wrap test
    always_comb begin
        rdQual = monitorRun && arHs && (!readIdFilterOn || arObs.id == readIdMatch);
        wrQual = monitorRun && awHs &&
                 (!writeIdFilterOn || awObs.id[APM_WID_W-1:0] == writeIdMatch);
        // wrap test keeps wrapping bursts only
        if (wrapTestSelect) begin
            rdQual = rdQual && arObs.burst == APM_BURST_WRAP;
            wrQual = wrQual && awObs.burst == APM_BURST_WRAP;
        end
        // beats per burst or one per transaction
        rdStep = countModeSelect ? {1'b0, arObs.len} + 9'h001 : 9'h001;
        wrStep = countModeSelect ? {1'b0, awObs.len} + 9'h001 : 9'h001;
    end

    // ----------------------------------------------------------------
    // read latency tracker
    // ----------------------------------------------------------------
    typedef enum logic [0:0] {APM_LAT_IDLE, APM_LAT_TRACK} apm_lat_state_t;
    apm_lat_state_t       lat_reg,    lat_next;
    logic [APM_LAT_W-1:0] latCnt_reg, latCnt_next;  // saturating cycles
    logic [APM_RID_W-1:0] latId_reg,  latId_next;   // id being timed
    logic [APM_LAT_W-1:0] max_reg,    max_next;     // largest seen
    logic                 overEvt;                  // read over limit
    logic                 latDone;                  // tracked read ended

    // one read timed at a time; others pass unseen to keep area small
    always_comb begin
        lat_next    = lat_reg;
        latCnt_next = latCnt_reg;
        latId_next  = latId_reg;
        max_next    = max_reg;
        overEvt     = 1'b0;
        latDone     = 1'b0;
        case (lat_reg)
            APM_LAT_IDLE: begin
                // optional restriction to one read id
                if (monitorRun && !counterWipe && arHs &&
                    (!latencyIdRangeOn || arObs.id == latencyIdSelect)) begin
                    lat_next    = APM_LAT_TRACK;
                    latCnt_next = {{(APM_LAT_W-1){1'b0}}, 1'b1};
                    latId_next  = arObs.id;
                end
            end
            APM_LAT_TRACK: begin
                if (latCnt_reg != '1) begin
                    latCnt_next = latCnt_reg + {{(APM_LAT_W-1){1'b0}}, 1'b1};
                end
                if (rHs && rObs.last && rObs.id == latId_reg) begin
                    latDone  = 1'b1;
                    lat_next = APM_LAT_IDLE;
                    overEvt  = latCnt_reg > {1'b0, readLatencyLimit};
                    if (latCnt_reg > max_reg) begin
                        max_next = latCnt_reg;
                    end
                end
            end
            default: lat_next = APM_LAT_IDLE;
        endcase
        // wipe forces results and tracker back to zero
        if (counterWipe) begin
            lat_next = APM_LAT_IDLE;
            max_next = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            lat_reg    <= APM_LAT_IDLE;
            latCnt_reg <= '0;
            latId_reg  <= '0;
            max_reg    <= '0;
        end else begin
            lat_reg    <= lat_next;
            latCnt_reg <= latCnt_next;
            latId_reg  <= latId_next;
            max_reg    <= max_next;
        end
    end

    // ----------------------------------------------------------------
    // result counters
    // ----------------------------------------------------------------
    logic [CNT_W-1:0] rdCount, wrCount, overCount;
    logic             rdWrap, wrWrap, overWrap;

    // wipe holds, run gates via the qualifiers
    apm_event_counter #(.W(CNT_W), .STEP_W(9)) uRdCnt (
        .clk(clk), .rst_b(rst_b), .wipe(counterWipe), .inc(rdQual),
        .step(rdStep), .count(rdCount), .wrapped(rdWrap));
    apm_event_counter #(.W(CNT_W), .STEP_W(9)) uWrCnt (
        .clk(clk), .rst_b(rst_b), .wipe(counterWipe), .inc(wrQual),
        .step(wrStep), .count(wrCount), .wrapped(wrWrap));
    apm_event_counter #(.W(CNT_W), .STEP_W(9)) uOverCnt (
        .clk(clk), .rst_b(rst_b), .wipe(counterWipe), .inc(overEvt),
        .step(9'h001), .count(overCount), .wrapped(overWrap));

    // ----------------------------------------------------------------
    // register writes, status and interrupt
    // ----------------------------------------------------------------
    always_comb begin
        ctrl_next = ctrl_reg;
        thr_next  = thr_reg;
        filt_next = filt_reg;
        mask_next = mask_reg;
        irqWipe   = 1'b0;
        stat_next = stat_reg;
        if (wrTake) begin
            // per-bit write enable from the upper half for ctrl, thr and filt; stat clears the bits set in pwdata[1:0], mask takes pwdata[1:0]
            case (paddr)
                APM_OFF_CTRL: ctrl_next = apm_merge(ctrl_reg, pwdata, APM_CTRL_WMASK);
                APM_OFF_THR:  thr_next  = apm_merge(thr_reg, pwdata, APM_THR_WMASK);
                APM_OFF_FILT: begin
                    filt_next = apm_merge(filt_reg, pwdata, APM_FILT_WMASK);
                    irqWipe = pwdata[APM_B_IRQWIPE] && pwdata[APM_WE_LSB + APM_B_IRQWIPE];
                end
                APM_OFF_STAT: stat_next = stat_reg & ~pwdata[1:0];
                APM_OFF_MASK: mask_next = pwdata[1:0];
                default:      stat_next = stat_reg;
            endcase
        end
        if (irqWipe) begin
            stat_next = '0;
        end
        // new events win over any clear in the same cycle
        stat_next[APM_ST_OVER]    = stat_next[APM_ST_OVER] | overEvt;
        stat_next[APM_ST_WRAPPED] = stat_next[APM_ST_WRAPPED] | rdWrap | wrWrap | overWrap;
        // irq gated by enable and mask
        irq_next = irqAllow && |(stat_next & mask_next);
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            ctrl_reg <= APM_CTRL_RST;
            thr_reg  <= APM_THR_RST;
            filt_reg <= APM_FILT_RST;
            stat_reg <= APM_EVT_RST;
            mask_reg <= APM_EVT_RST;
            irq_reg  <= 1'b0;
        end else begin
            ctrl_reg <= ctrl_next;
            thr_reg  <= thr_next;
            filt_reg <= filt_next;
            stat_reg <= stat_next;
            mask_reg <= mask_next;
            irq_reg  <= irq_next;
        end
    end

    // ----------------------------------------------------------------
    // apb read path: answer is ready in the first access cycle
    // ----------------------------------------------------------------
    always_comb begin
        mapped = 1'b1;
        rdMux  = 32'h0000_0000;
        case (paddr)
            APM_OFF_CTRL:   rdMux = {16'h0000, ctrl_reg};
            APM_OFF_THR:    rdMux = {16'h0000, thr_reg};
            APM_OFF_FILT:   rdMux = {16'h0000, filt_reg};
            APM_OFF_MAXLAT: rdMux = {{(32-APM_LAT_W){1'b0}}, max_reg};
            APM_OFF_OVERCT: rdMux = overCount;
            APM_OFF_RDCNT:  rdMux = rdCount;
            APM_OFF_WRCNT:  rdMux = wrCount;
            APM_OFF_STAT:   rdMux = {30'h0000_0000, stat_reg};
            APM_OFF_MASK:   rdMux = {30'h0000_0000, mask_reg};
            default:        mapped = 1'b0;
        endcase
        prdata_next  = setupPh && !pwrite && mapped ? rdMux : 32'h0000_0000;
        pready_next  = setupPh;
        pslverr_next = setupPh && !mapped;
    end

    always_ff @(posedge clk) begin
        if (!rst_b) begin
            prdata_reg  <= 32'h0000_0000;
            pready_reg  <= 1'b0;
            pslverr_reg <= 1'b0;
        end else begin
            prdata_reg  <= prdata_next;
            pready_reg  <= pready_next;
            pslverr_reg <= pslverr_next;
        end
    end

    assign prdata  = prdata_reg;
    assign pready  = pready_reg;
    assign pslverr = pslverr_reg;
    assign irq     = irq_reg;

    // ----------------------------------------------------------------
    // checks
    // ----------------------------------------------------------------
    sequence apbWrCtrl;
        psel && penable && pready && pwrite && paddr == APM_OFF_CTRL;
    endsequence

    masked_write_a: assert property (@(posedge clk) disable iff (!rst_b)
        apbWrCtrl |=> ctrl_reg == $past(apm_merge(ctrl_reg, pwdata, APM_CTRL_WMASK)))
        else $error("masked control write wrong");
    thr_reserved_a: assert property (@(posedge clk) disable iff (!rst_b)
        thr_reg[15:12] == 4'h0)
        else $error("reserved limit bits set");
    rd_filter_a: assert property (@(posedge clk) disable iff (!rst_b)
        rdQual |-> (!readIdFilterOn || arObs.id == readIdMatch))
        else $error("filtered read counted");
    wr_filter_a: assert property (@(posedge clk) disable iff (!rst_b)
        wrQual |-> (!writeIdFilterOn || awObs.id[4:0] == writeIdMatch))
        else $error("filtered write counted");
    wrap_only_a: assert property (@(posedge clk) disable iff (!rst_b)
        (wrapTestSelect && rdQual) |-> arObs.burst == APM_BURST_WRAP)
        else $error("non-wrap burst counted in wrap test");
    mode_step_a: assert property (@(posedge clk) disable iff (!rst_b)
        !countModeSelect |-> rdStep == 9'h001)
        else $error("transaction mode step not one");
    run_gate_a: assert property (@(posedge clk) disable iff (!rst_b)
        (!monitorRun && !counterWipe) |=> rdCount == $past(rdCount))
        else $error("count moved while stopped");
    irq_clear_a: assert property (@(posedge clk) disable iff (!rst_b)
        (irqWipe && !overEvt && !rdWrap && !wrWrap && !overWrap) |=> stat_reg == 2'h0)
        else $error("interrupt status not cleared");
    irq_level_a: assert property (@(posedge clk) disable iff (!rst_b)
        irq |-> $past(irqAllow, 1) || !$past(rst_b))
        else $error("irq raised while disabled");
    over_count_a: assert property (@(posedge clk) disable iff (!rst_b)
        (overEvt && !counterWipe) |=> overCount == $past(overCount) + 1)
        else $error("over-limit read not counted");
    max_track_a: assert property (@(posedge clk) disable iff (!rst_b)
        (latDone && !counterWipe) |=> max_reg >= $past(latCnt_reg))
        else $error("maximum latency not updated");
    lat_select_a: assert property (@(posedge clk) disable iff (!rst_b)
        (lat_reg == APM_LAT_IDLE && lat_next == APM_LAT_TRACK && latencyIdRangeOn)
        |-> arObs.id == latencyIdSelect)
        else $error("latency tracked for wrong id");
endmodule
`default_nettype wire

/* File: verification/apm_axi_partner.sv */
`timescale 1ns/1ns
`default_nettype none
// ----------------------------------------------------------------
// cluster-side axi traffic
// ----------------------------------------------------------------
module apm_axi_partner
    import apm_pkg::*;
(
    input  wire logic     clk,
    output var apm_addr_obs_t  ar,
    output var apm_rdata_obs_t r,
    output var apm_addr_obs_t  aw
);
    initial begin
        ar = '0;
        r  = '0;
        aw = '0;
    end
    // one read: st stall cycles before ready, last beat lat cycles later
    task automatic rd(input logic [5:0] id, input logic [7:0] len,
                      input logic [1:0] b, input int lat, input int st);
        ar <= '{1'b1, st == 0, id, len, b};
        repeat (st) @(posedge clk);
        if (st > 0) ar.ready <= 1'b1;
        @(posedge clk);
        // idle id is scrambled so a stale id never matches
        ar <= '{1'b0, 1'b0, ~id, len, b};
        repeat (lat - 1) @(posedge clk);
        r <= '{1'b1, 1'b1, 1'b1, id};
        @(posedge clk);
        r <= '{1'b0, 1'b0, 1'b0, ~id};
        @(posedge clk);
    endtask
    task automatic wr(input logic [4:0] id, input logic [1:0] b);
        aw <= '{1'b1, 1'b1, {1'b0, id}, 8'h00, b};
        @(posedge clk);
        aw <= '{1'b0, 1'b0, {1'b1, ~id}, 8'h00, b};
        @(posedge clk);
    endtask
endmodule
`default_nettype wire

/* File: verification/test_apm_monitor_ctrl.sv */
`timescale 1ns/1ns
`default_nettype none
module test_apm_monitor_ctrl
    import apm_pkg::*;
;
    logic           clk = 1'b0;
    logic           rst_b = 1'b0;
    logic           psel = 1'b0;
    logic           penable = 1'b0;
    logic           pwrite = 1'b0;
    logic [7:0]     paddr = 8'h00;
    logic [31:0]    pwdata = 32'h0;
    logic [31:0]    prdata;
    logic           pready, pslverr, irq;
    apm_addr_obs_t  arObs, awObs;
    apm_rdata_obs_t rObs;
    logic [32:0]    expQ [$]; // pending {err, data}
    logic [15:0]    sh [3] = '{16'h0, 16'h0, 16'h0};
    logic [15:0]    wm [3] = '{APM_CTRL_WMASK, APM_THR_WMASK, APM_FILT_WMASK};
    logic [7:0]     offs [9] = '{APM_OFF_CTRL, APM_OFF_THR, APM_OFF_FILT,
        APM_OFF_MAXLAT, APM_OFF_OVERCT, APM_OFF_RDCNT, APM_OFF_WRCNT,
        APM_OFF_STAT, APM_OFF_MASK};
    logic [31:0]    d;
    int             fail_count = 0;
    int             n_checks = 0;
    int             cyc = 0;
    integer         seed = 32'he787;
    initial forever #5 clk = ~clk;
    apm_monitor_ctrl u_dut (.clk(clk), .rst_b(rst_b), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr), .arObs(arObs),
        .rObs(rObs), .awObs(awObs), .irq(irq));
    apm_axi_partner u_axi (.clk(clk), .ar(arObs), .r(rObs), .aw(awObs));
    task automatic chk(input string n, input logic [32:0] got, input logic [32:0] e);
        n_checks++;
        if (got !== e) begin
            fail_count++;
            $display("[FAIL] %s exp %h got %h", n, e, got);
        end
    endtask
    // apb transfer, held until pready is sampled high
    task automatic w(input logic [7:0] a, input logic [31:0] wd, input logic wr = 1'b1);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= wd;
        @(posedge clk);
        penable <= 1'b1;
        @(posedge clk);
        while (pready !== 1'b1) @(posedge clk);
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge clk);
    endtask
    task automatic r(input logic [7:0] a, input logic [32:0] e);
        expQ.push_back(e);
        w(a, 32'h0, 1'b0);
    endtask
    task automatic wipe(input logic [31:0] c);
        w(APM_OFF_CTRL, 32'h0002_0002);
        w(APM_OFF_CTRL, c);
    endtask
    task automatic irqIs(input logic e);
        repeat (2) @(posedge clk);
        chk("irq", {32'h0, irq}, {32'h0, e});
    endtask
    // watcher: each read answer against the oldest note
    always @(posedge clk) begin
        if (psel && penable && pready && !pwrite)
            chk($sformatf("read %h", paddr), {pslverr, prdata}, expQ.pop_front());
    end
    task automatic wrap_up();
        $display("checks %0d mismatches %0d", n_checks, fail_count);
        if (fail_count == 0 && n_checks > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fail_count++;
            wrap_up();
        end
    end
    initial begin
        repeat (20) @(posedge clk);
        rst_b <= 1'b1;
        @(posedge clk);
        foreach (offs[i]) r(offs[i], 33'h0);
        r(8'h10, {1'b1, 32'h0});
        for (int k = 0; k < 12; k++) begin
            d = $random(seed);
            w(offs[k % 3], d);
            sh[k % 3] = (sh[k % 3] & ~d[31:16]) | (d[15:0] & d[31:16] & wm[k % 3]);
            r(offs[k % 3], {17'h0, sh[k % 3]});
        end
        w(APM_OFF_CTRL, 32'hffff_ffff);
        r(APM_OFF_CTRL, 33'h0_0000_bfff);
        w(APM_OFF_THR, 32'hffff_ffff);
        w(APM_OFF_THR, 32'h0000_0123);
        r(APM_OFF_THR, 33'h0_0000_0fff);
        $display("test registers done");
        w(APM_OFF_CTRL, 32'hffff_0001);
        w(APM_OFF_THR, 32'hffff_0000);
        u_axi.rd(6'h01, 8'h03, 2'h1, 2, 1);
        u_axi.rd(6'h02, 8'h00, 2'h1, 3, 0);
        u_axi.wr(5'h03, 2'h1);
        u_axi.wr(5'h04, 2'h1);
        r(APM_OFF_RDCNT, 33'h2);
        r(APM_OFF_WRCNT, 33'h2);
        r(APM_OFF_OVERCT, 33'h2);
        r(APM_OFF_MAXLAT, 33'h3);
        wipe(32'h0006_0004);
        u_axi.rd(6'h01, 8'h03, 2'h1, 1, 0);
        r(APM_OFF_RDCNT, 33'h4);
        wipe(32'h000e_0008);
        u_axi.rd(6'h01, 8'h00, 2'h1, 1, 0);
        u_axi.rd(6'h01, 8'h00, 2'h2, 1, 0);
        u_axi.wr(5'h01, 2'h2);
        r(APM_OFF_RDCNT, 33'h1);
        r(APM_OFF_WRCNT, 33'h1);
        w(APM_OFF_FILT, 32'h1f3f_0a05);
        wipe(32'h003a_0030);
        u_axi.rd(6'h05, 8'h00, 2'h1, 1, 0);
        u_axi.rd(6'h25, 8'h00, 2'h1, 1, 0);
        u_axi.wr(5'h0a, 2'h1);
        u_axi.wr(5'h0b, 2'h1);
        u_axi.wr(5'h0a, 2'h1);
        r(APM_OFF_RDCNT, 33'h1);
        r(APM_OFF_WRCNT, 33'h2);
        $display("test counting done");
        wipe(32'h003e_0000);
        w(APM_OFF_THR, 32'hffff_0005);
        w(APM_OFF_STAT, 32'h3);
        w(APM_OFF_MASK, 32'h1);
        w(APM_OFF_FILT, 32'h4000_4000);
        u_axi.rd(6'h07, 8'h00, 2'h1, 5, 0);
        irqIs(1'b0);
        u_axi.rd(6'h07, 8'h00, 2'h1, 9, 0);
        irqIs(1'b1);
        r(APM_OFF_OVERCT, 33'h1);
        r(APM_OFF_MAXLAT, 33'h9);
        w(APM_OFF_MASK, 32'h0);
        irqIs(1'b0);
        w(APM_OFF_MASK, 32'h1);
        w(APM_OFF_FILT, 32'h0000_8000);
        irqIs(1'b1);
        w(APM_OFF_FILT, 32'h8000_8000);
        irqIs(1'b0);
        r(APM_OFF_STAT, 33'h0);
        // latency timing restricted to one read id: the slow read of another id is ignored
        wipe(32'hbf02_8700);
        u_axi.rd(6'h09, 8'h00, 2'h1, 7, 0);
        u_axi.rd(6'h07, 8'h00, 2'h1, 3, 0);
        r(APM_OFF_MAXLAT, 33'h3);
        r(APM_OFF_OVERCT, 33'h0);
        $display("test latency done");
        wrap_up();
    end
endmodule
`default_nettype wire
